/* hw/fscfg_top.sv */
// Status, configuration, identifier lock and pause logic of the serial flash
`timescale 1ns/1ps
`default_nettype none
module fscfg_top
  import fscfg_pkg::*;
#(
  parameter logic QPS_DEFAULT = 1'b0
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 ce_n,
  input  wire logic                 sck,
  input  wire logic                 si,
  output logic                      so,
  output logic                      so_oe_n,
  input  wire logic                 data_line_three_n,
  input  wire logic                 data_line_two_n,
  input  wire logic                 quad_mode,
  input  wire logic                 busy_in,
  input  wire logic                 erase_active,
  input  wire logic                 nv_protect_pin_enable,
  input  wire logic                 nv_id_locked,
  input  wire logic                 nv_lock_absent,
  input  wire logic                 ev_write_enable,
  input  wire logic                 write_disable_cmd,
  input  wire logic                 ev_soft_reset,
  input  wire logic                 ev_op_done,
  input  wire logic                 ev_suspend,
  input  wire logic                 ev_resume,
  input  wire logic                 ev_perm_lock_prog,
  input  wire logic                 modify_req,
  output logic                      modify_grant,
  input  wire logic                 lockdown_req,
  input  wire logic                 lockout_identifier_cmd,
  input  wire logic                 program_identifier_cmd,
  input  wire logic                 id_is_erase,
  input  wire logic [ID_ADDR_W-1:0] id_addr,
  output logic                      id_grant,
  output logic                      quad_cmd_reject,
  output logic                      paused,
  output logic                      hw_protected,
  output logic                      protect_write_stb,
  output fscfg_status_type          device_status,
  output fscfg_config_type          device_configuration
);

  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic              sck_prev_reg;
  logic              ce_s, sck_s, si_s, hold_s, wp_s;
  logic              sck_rise, sck_fall;
  logic              load_pending_reg;
  logic              busy_reg;
  logic              wel_reg;
  logic              erase_susp_reg;
  logic              prog_susp_reg;
  logic              lockdown_reg;
  logic              id_locked_reg;
  logic              qps_reg;
  logic              protect_pin_enable_reg;
  logic              lock_absent_reg;
  logic              paused_reg;
  logic              hold_enable;
  fscfg_state_type   state_reg;
  logic [3:0]        bit_cnt_reg;
  logic [7:0]        shift_reg;
  logic [7:0]        opcode_next;
  logic              read_cfg_reg;
  logic [2:0]        out_cnt_reg;
  logic              so_reg;
  logic              cfg_write_pulse;
  logic              lockdown_ok;
  logic              lockout_ok;
  logic [7:0]        status_byte;
  logic [7:0]        config_byte;

  // Two-stage synchronisers for every pin
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          sync1_reg[gi] <= (gi == SY_SCK || gi == SY_SI) ? 1'b0 : 1'b1;
          sync2_reg[gi] <= (gi == SY_SCK || gi == SY_SI) ? 1'b0 : 1'b1;
        end else begin
          sync1_reg[gi] <= (gi == SY_CE)   ? ce_n :
                           (gi == SY_SCK)  ? sck :
                           (gi == SY_SI)   ? si :
                           (gi == SY_HOLD) ? data_line_three_n : data_line_two_n;
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sync2_reg[SY_SCK];
    end
  end

  assign ce_s     = sync2_reg[SY_CE];
  assign sck_s    = sync2_reg[SY_SCK];
  assign si_s     = sync2_reg[SY_SI];
  assign hold_s   = sync2_reg[SY_HOLD];
  assign wp_s     = sync2_reg[SY_WP];
  assign sck_rise = sck_s & ~sck_prev_reg & ~paused_reg & ~ce_s;
  assign sck_fall = ~sck_s & sck_prev_reg & ~paused_reg & ~ce_s;

  // Pins double as data lines once quad select is set or in quad mode
  assign hold_enable  = ~quad_mode & ~qps_reg;
  assign hw_protected = ~quad_mode & ~qps_reg & protect_pin_enable_reg & ~wp_s;

  // Level checks give the "wait for next clock low" behaviour for free
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      paused_reg <= 1'b0;
    end else if (!hold_enable) begin
      paused_reg <= 1'b0;
    end else if (!paused_reg) begin
      if (!ce_s && !hold_s && !sck_s) begin
        paused_reg <= 1'b1;
      end
    end else if (hold_s && !sck_s) begin
      paused_reg <= 1'b0;
    end
  end

  assign paused = paused_reg;

  // Non-volatile values are caught one cycle after reset release
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      load_pending_reg <= 1'b1;
    end else begin
      load_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= busy_in;
    end
  end

  assign lockdown_ok = lockdown_req & wel_reg;
  assign lockout_ok  = lockout_identifier_cmd & wel_reg;

  // Write-enable latch: a same-cycle enable beats any clearing event
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wel_reg <= 1'b0;
    end else if (ev_write_enable) begin
      wel_reg <= 1'b1;
    end else if (ev_soft_reset || write_disable_cmd || ev_op_done || ev_suspend ||
                 lockdown_ok || lockout_ok || cfg_write_pulse) begin
      wel_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      erase_susp_reg <= 1'b0;
    end else if (ev_suspend && busy_reg && erase_active) begin
      erase_susp_reg <= 1'b1;
    end else if (ev_resume && erase_active) begin
      erase_susp_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prog_susp_reg <= 1'b0;
    end else if (ev_suspend && busy_reg && !erase_active) begin
      prog_susp_reg <= 1'b1;
    end else if (ev_resume && !erase_active) begin
      prog_susp_reg <= 1'b0;
    end
  end

  // Soft reset leaves this alone; only power-up clears it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lockdown_reg <= 1'b0;
    end else if (lockdown_ok) begin
      lockdown_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      id_locked_reg <= 1'b0;
    end else if (lockout_ok || (load_pending_reg && nv_id_locked)) begin
      id_locked_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lock_absent_reg <= 1'b1;
    end else if (ev_perm_lock_prog || (load_pending_reg && !nv_lock_absent)) begin
      lock_absent_reg <= 1'b0;
    end
  end

  // Only bits 1 and 7 are writable; others ignore the written byte
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      qps_reg  <= QPS_DEFAULT;
      protect_pin_enable_reg <= CFG_PROT_RESET;
    end else if (load_pending_reg) begin
      protect_pin_enable_reg <= nv_protect_pin_enable;
    end else if (cfg_write_pulse) begin
      qps_reg  <= opcode_next[1];
      protect_pin_enable_reg <= opcode_next[7];
    end
  end

  assign protect_write_stb = cfg_write_pulse;

  assign modify_grant = modify_req & wel_reg;
  // Erase has no grant path; the unique part is never programmable
  assign id_grant = program_identifier_cmd & ~id_is_erase & wel_reg & ~id_locked_reg &
                    (id_addr >= ID_ADDR_W'(ID_UNIQUE_BYTES));

  assign opcode_next = {shift_reg[6:0], si_s};

  // Serial command engine, single-bit framing only
  always_ff @(posedge clk_sys) begin
    if (!rst_n || ce_s) begin
      state_reg    <= FSCFG_OPCODE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      read_cfg_reg <= 1'b0;
    end else if (sck_rise) begin
      shift_reg   <= opcode_next;
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      case (state_reg)
        FSCFG_OPCODE: begin
          if (bit_cnt_reg[2:0] == BYTE_LAST_BIT) begin
            bit_cnt_reg <= 4'h0;
            if (opcode_next == OPC_READ_STATUS || opcode_next == OPC_READ_CONFIG) begin
              state_reg    <= FSCFG_READ;
              read_cfg_reg <= (opcode_next == OPC_READ_CONFIG);
            end else if (opcode_next == OPC_WRITE_STATUS) begin
              state_reg <= FSCFG_WRITE;
            end
          end
        end
        FSCFG_WRITE: begin
          if (bit_cnt_reg == WRSR_LAST_BIT) begin
            state_reg <= FSCFG_OPCODE;
          end
        end
        FSCFG_READ: begin
          bit_cnt_reg <= 4'h0;
        end
        default: begin
          state_reg <= FSCFG_OPCODE;
        end
      endcase
    end
  end

  assign cfg_write_pulse = sck_rise && (state_reg == FSCFG_WRITE) &&
                           (bit_cnt_reg == WRSR_LAST_BIT) && wel_reg && !hw_protected;

  // Quad commands decoded while the pins still carry control functions
  assign quad_cmd_reject = sck_rise && (state_reg == FSCFG_OPCODE) &&
                           (bit_cnt_reg[2:0] == BYTE_LAST_BIT) && !qps_reg && !quad_mode &&
                           (opcode_next == OPC_QUAD_OUT_RD || opcode_next == OPC_QUAD_IO_RD ||
                            opcode_next == OPC_WRAP_BURST || opcode_next == OPC_QUAD_PROG);

  assign device_status = '{busy_dup: busy_reg, reserved6: 1'b0, id_locked: id_locked_reg,
                           lockdown: lockdown_reg, prog_susp: prog_susp_reg,
                           erase_susp: erase_susp_reg, write_enable_latch: wel_reg, busy: busy_reg};
  assign device_configuration = '{protect_pin_enable: protect_pin_enable_reg, reserved6_4: 3'h0,
                                  permanent_lock_absent: lock_absent_reg, reserved2: 1'b0,
                                  quad_pin_select: qps_reg, reserved0: 1'b0};
  assign status_byte = device_status;
  assign config_byte = device_configuration;

  // Live register value each bit so polling sees busy drop promptly
  always_ff @(posedge clk_sys) begin
    if (!rst_n || ce_s || state_reg != FSCFG_READ) begin
      out_cnt_reg <= 3'h0;
      so_reg      <= 1'b0;
    end else if (sck_fall) begin
      so_reg      <= read_cfg_reg ? config_byte[BYTE_LAST_BIT - out_cnt_reg]
                                  : status_byte[BYTE_LAST_BIT - out_cnt_reg];
      out_cnt_reg <= out_cnt_reg + 3'h1;
    end
  end

  assign so      = so_reg;
  assign so_oe_n = ~((state_reg == FSCFG_READ) & ~ce_s & ~paused_reg);

  AST_WEL_REFUSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !wel_reg |-> !modify_grant && !lockdown_ok) else $error("modify granted without latch");
  AST_ID_LOCKED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    id_locked_reg |-> !id_grant) else $error("identifier program after lockout");
  AST_ID_NO_ERASE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    id_is_erase |-> !id_grant) else $error("identifier erase granted");
  AST_ID_UNIQUE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    id_grant |-> id_addr >= ID_ADDR_W'(ID_UNIQUE_BYTES)) else $error("unique part written");
  AST_PAUSE_HIZ: assert property (@(posedge clk_sys) disable iff (!rst_n)
    paused_reg |-> so_oe_n) else $error("output driven while paused");
  AST_PAUSE_QUAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    quad_mode |=> !paused_reg) else $error("pause active in quad mode");
  AST_PAUSE_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hold_enable && !paused_reg && !ce_s && !hold_s && !sck_s |=> paused_reg)
    else $error("pause not entered");
  AST_BUSY_BOTH: assert property (@(posedge clk_sys) disable iff (!rst_n)
    busy_in |=> device_status.busy && device_status.busy_dup) else $error("busy missing");
  AST_LOCKDOWN_STICKY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lockdown_reg |=> lockdown_reg) else $error("lockdown flag cleared");
  AST_IDLOCK_STICKY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lockout_ok |=> id_locked_reg [*3]) else $error("identifier lock lost");
  AST_WEL_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    write_disable_cmd && !ev_write_enable |=> !wel_reg) else $error("latch not cleared");
  AST_QUAD_REJECT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    quad_cmd_reject |-> !qps_reg) else $error("quad reject with select set");
  AST_RESERVED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (config_byte & 8'h75) == 8'h00 && !status_byte[6]) else $error("reserved bit set");

  COV_PAUSE: cover property (@(posedge clk_sys) disable iff (!rst_n)
    !paused_reg ##1 paused_reg ##[1:200] !paused_reg);
  COV_CFG_WRITE: cover property (@(posedge clk_sys) disable iff (!rst_n) cfg_write_pulse);
  COV_STATUS_POLL: cover property (@(posedge clk_sys) disable iff (!rst_n)
    busy_reg && state_reg == FSCFG_READ && sck_fall);
  COV_SUSPEND: cover property (@(posedge clk_sys) disable iff (!rst_n)
    erase_susp_reg ##[1:100] !erase_susp_reg);

endmodule : fscfg_top
`default_nettype wire

/* pkg/fscfg_pkg.sv */
// Constants and carrier types for the flash status and configuration block
// Behaviour
// - Identifier space is 2 KByte: fixed 64-bit unique part plus user part.
// - After identifier lockout, every identifier program request is refused.
// - Neither identifier segment is ever erased.
// - Pause works from power-up in single and dual modes, never in quad mode.
// - Pause starts when pause pin is low with clock low and select low.
// - Pause ends when pause pin is high while clock is low.
// - While paused, output is released and input and clock are ignored.
// - Select high during pause resets the serial interface logic.
// - Status register stays readable while an internal operation runs.
// - Status layout: busy, latch, erase susp, prog susp, lockdown, id lock, 0, busy.
// - Both busy bits show the running internal operation; power-up value 0.
// - With latch clear, program, erase, protection write and lockdown are refused.
// - Latch clears on power-up, reset, disable and each listed completion.
// - Erase-suspended flag sets on suspend during erase, clears on resume.
// - Program-suspended flag sets on suspend during program, clears on resume.
// - Lockdown flag sets on lockdown command; only power cycle clears it.
// - Identifier-locked flag sets on lockout and is never cleared.
// - Config layout: bit1 quad select, bit3 lock absent, bit7 protect enable.
// - Quad select 1 turns protect and pause pins into data lines.
// - Quad commands are invalid while quad select is 0.
// - Quad mode ignores quad select; its power-up value is a variant choice.
// - Protect enable is non-volatile, factory value 0.
// - Lock-absent reads 0 forever once a permanent lockdown bit is programmed.
package fscfg_pkg;

  localparam int unsigned ID_SPACE_BYTES  = 2048;
  localparam int unsigned ID_UNIQUE_BITS  = 64;
  localparam int unsigned ID_UNIQUE_BYTES = ID_UNIQUE_BITS / 8;
  localparam int unsigned ID_ADDR_W       = $clog2(ID_SPACE_BYTES);

  localparam logic [7:0] OPC_READ_STATUS  = 8'h05;
  localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OPC_READ_CONFIG  = 8'h35;
  localparam logic [7:0] OPC_QUAD_OUT_RD  = 8'h6b;
  localparam logic [7:0] OPC_QUAD_IO_RD   = 8'heb;
  localparam logic [7:0] OPC_WRAP_BURST   = 8'hec;
  localparam logic [7:0] OPC_QUAD_PROG    = 8'h32;

  localparam logic [2:0] SYNC_W = 3'h5;
  localparam int unsigned SY_CE = 0;
  localparam int unsigned SY_SCK = 1;
  localparam int unsigned SY_SI = 2;
  localparam int unsigned SY_HOLD = 3;
  localparam int unsigned SY_WP = 4;

  localparam logic [3:0] WRSR_LAST_BIT = 4'hf;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic       CFG_PROT_RESET = 1'b0;

  typedef struct packed {
    logic busy_dup;
    logic reserved6;
    logic id_locked;
    logic lockdown;
    logic prog_susp;
    logic erase_susp;
    logic write_enable_latch;
    logic busy;
  } fscfg_status_type;

  typedef struct packed {
    logic       protect_pin_enable;
    logic [2:0] reserved6_4;
    logic       permanent_lock_absent;
    logic       reserved2;
    logic       quad_pin_select;
    logic       reserved0;
  } fscfg_config_type;

  typedef enum logic [2:0] {
    FSCFG_OPCODE = 3'b001,
    FSCFG_READ   = 3'b010,
    FSCFG_WRITE  = 3'b100
  } fscfg_state_type;

endpackage : fscfg_pkg

/* verif/fscfg_host.sv */
// Host serial controller model driving the flash pins
`timescale 1ns/1ps
`default_nettype none
module fscfg_host (
  input  wire logic clk_sys,
  output logic      ce_n,
  output logic      sck,
  output logic      si,
  output logic      data_line_three_n,
  input  wire logic so,
  input  wire logic so_oe_n,
  input  wire logic paused
);
  initial begin
    ce_n              = 1'b1;
    sck               = 1'b0;
    si                = 1'b0;
    data_line_three_n = 1'b1;
  end

  // Half link period of 40 ns; clock stands low between frames
  task automatic step();
    repeat (5) @(posedge clk_sys);
    #1;
  endtask : step

  // Opcode plus nw write bits; with none, one byte is read back
  task automatic xfer(input logic [7:0] opc, input logic [15:0] wd, input int nw,
                      output logic [7:0] rd);
    logic [23:0] sh;
    sh = {opc, wd};
    rd = 8'h00;
    step();
    ce_n = 1'b0;
    for (int i = 0; i < 8 + nw; i++) begin
      step();
      sck = 1'b0;
      si = sh[23-i];
      step();
      sck = 1'b1;
    end
    for (int i = 0; i < ((nw == 0) ? 8 : 0); i++) begin
      step();
      sck = 1'b0;
      si = ~si;
      step();
      sck = 1'b1;
      // Released line reads inverted so a late enable shows up
      rd = {rd[6:0], so ^ so_oe_n};
    end
    step();
    sck = 1'b0;
    step();
    ce_n = 1'b1;
    si = ~si;
  endtask : xfer

  // Pause entry and exit with the pin moving while the clock is high
  task automatic pause_seq(output logic [4:0] obs);
    step();
    ce_n = 1'b0;
    step();
    sck = 1'b1;
    step();
    data_line_three_n = 1'b0;
    step();
    obs[0] = paused;
    sck = 1'b0;
    step();
    obs[1] = paused;
    obs[2] = so_oe_n;
    sck = 1'b1;
    si = ~si;
    step();
    data_line_three_n = 1'b1;
    step();
    obs[3] = paused;
    sck = 1'b0;
    step();
    obs[4] = paused;
    data_line_three_n = 1'b0;
    step();
    ce_n = 1'b1;
    step();
    data_line_three_n = 1'b1;
    step();
  endtask : pause_seq
endmodule : fscfg_host
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the status, configuration and pause block
`timescale 1ns/1ps
`default_nettype none
module tb
  import fscfg_pkg::*;
;
  logic                 clk_sys, rst_n, ce_n, sck, si, so, so_oe_n, data_line_three_n;
  logic                 data_line_two_n, quad_mode, busy_in, erase_active;
  logic                 nv_pe, nv_il, nv_la, ev_write_enable, write_disable_cmd;
  logic                 ev_soft_reset, ev_op_done, ev_suspend, ev_resume, ev_perm_lock_prog;
  logic                 modify_req, modify_grant, lockdown_req, lockout_identifier_cmd;
  logic                 program_identifier_cmd, id_is_erase, id_grant, quad_cmd_reject;
  logic                 paused, hw_protected, protect_write_stb;
  logic [ID_ADDR_W-1:0] id_addr;
  fscfg_status_type     device_status;
  fscfg_config_type     device_configuration;
  logic                 m_busy, m_wel, m_es, m_ps, m_ld, m_il, m_la;
  logic [31:0]          seed;
  logic [7:0]           rd;
  logic [4:0]           obs;
  int                   miscompares, checks_done, rej_cnt, stb_cnt, cyc;

  fscfg_top #(.QPS_DEFAULT(1'b0)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce_n(ce_n),
    .sck(sck), .si(si), .so(so), .so_oe_n(so_oe_n), .data_line_three_n(data_line_three_n),
    .data_line_two_n(data_line_two_n), .quad_mode(quad_mode), .busy_in(busy_in),
    .erase_active(erase_active), .nv_protect_pin_enable(nv_pe), .nv_id_locked(nv_il),
    .nv_lock_absent(nv_la), .ev_write_enable(ev_write_enable),
    .write_disable_cmd(write_disable_cmd), .ev_soft_reset(ev_soft_reset),
    .ev_op_done(ev_op_done), .ev_suspend(ev_suspend), .ev_resume(ev_resume),
    .ev_perm_lock_prog(ev_perm_lock_prog), .modify_req(modify_req),
    .modify_grant(modify_grant), .lockdown_req(lockdown_req),
    .lockout_identifier_cmd(lockout_identifier_cmd),
    .program_identifier_cmd(program_identifier_cmd), .id_is_erase(id_is_erase),
    .id_addr(id_addr), .id_grant(id_grant), .quad_cmd_reject(quad_cmd_reject),
    .paused(paused), .hw_protected(hw_protected), .protect_write_stb(protect_write_stb),
    .device_status(device_status), .device_configuration(device_configuration));

  fscfg_host host (.clk_sys(clk_sys), .ce_n(ce_n), .sck(sck), .si(si),
    .data_line_three_n(data_line_three_n), .so(so), .so_oe_n(so_oe_n), .paused(paused));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    rej_cnt <= rej_cnt + ((quad_cmd_reject === 1'b1) ? 1 : 0);
    stb_cnt <= stb_cnt + ((protect_write_stb === 1'b1) ? 1 : 0);
    cyc <= cyc + 1;
    // Whole run needs well under a third of this
    if (cyc == 30000) begin
      miscompares++;
      print_verdict();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [7:0] cfg_exp(input logic pe, input logic la, input logic q);
    return {pe, 3'h0, la, 1'b0, q, 1'b0};
  endfunction : cfg_exp

  function automatic logic [7:0] st_exp();
    return {m_busy, 1'b0, m_il, m_ld, m_ps, m_es, m_wel, m_busy};
  endfunction : st_exp

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic do_reset(input logic pe, input logic il, input logic la);
    {nv_pe, nv_il, nv_la} = {pe, il, la};
    busy_in = 1'b0;
    rst_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    {m_busy, m_wel, m_es, m_ps, m_ld, m_il, m_la} = {5'h00, il, la};
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : do_reset

  task automatic set_ev(input int s, input logic v);
    case (s)
      0: ev_write_enable = v;
      1: write_disable_cmd = v;
      2: ev_soft_reset = v;
      3: ev_op_done = v;
      4: ev_suspend = v;
      5: ev_resume = v;
      6: lockdown_req = v;
      7: lockout_identifier_cmd = v;
      default: ev_perm_lock_prog = v;
    endcase
  endtask : set_ev

  task automatic pulse_wel();
    set_ev(0, 1'b1);
    @(posedge clk_sys);
    #1;
    set_ev(0, 1'b0);
    m_wel = 1'b1;
  endtask : pulse_wel

  task automatic quad_burst();
    host.xfer(OPC_QUAD_OUT_RD, 16'h0000, 0, rd);
    host.xfer(OPC_QUAD_IO_RD, 16'h0000, 0, rd);
    host.xfer(OPC_WRAP_BURST, 16'h0000, 0, rd);
    host.xfer(OPC_QUAD_PROG, 16'h0000, 0, rd);
  endtask : quad_burst

  // One event per cycle; suspend only with no flag set keeps resume unambiguous
  task automatic rand_events(input int n);
    logic [31:0] r;
    int          s;
    logic        g;
    for (int k = 0; k < n; k++) begin
      r = rnd();
      s = r[19:16] % 9;
      if (s == 4 && (m_es || m_ps))
        s = 0;
      @(posedge clk_sys);
      #1;
      busy_in = (s == 4) ? m_busy : r[0];
      erase_active = (s == 5) ? m_es : r[20];
      {modify_req, program_identifier_cmd, id_is_erase} = r[3:1];
      id_addr = r[4] ? (r[5] ? 11'h007 : 11'h008) : r[15:5];
      set_ev(s, 1'b1);
      #1;
      check("modify_grant", {7'h00, modify_grant}, {7'h00, r[3] & m_wel});
      g = r[2] & !r[1] & m_wel & !m_il & (id_addr >= 11'h008);
      check("id_grant", {7'h00, id_grant}, {7'h00, g});
      case (s)
        0: m_wel = 1'b1;
        4: begin
          if (busy_in && erase_active)
            m_es = 1'b1;
          if (busy_in && !erase_active)
            m_ps = 1'b1;
          m_wel = 1'b0;
        end
        5: {m_es, m_ps} = erase_active ? {1'b0, m_ps} : {m_es, 1'b0};
        6: {m_ld, m_wel} = {m_ld | m_wel, 1'b0};
        7: {m_il, m_wel} = {m_il | m_wel, 1'b0};
        8: m_la = 1'b0;
        default: m_wel = 1'b0;
      endcase
      m_busy = busy_in;
      @(posedge clk_sys);
      #1;
      set_ev(s, 1'b0);
      check("status", device_status, st_exp());
      check("config", device_configuration, cfg_exp(1'b0, m_la, 1'b0));
    end
  endtask : rand_events

  initial begin
    {rst_n, quad_mode, busy_in, erase_active, modify_req, id_is_erase} = 6'h00;
    {lockdown_req, lockout_identifier_cmd, program_identifier_cmd} = 3'h0;
    {ev_write_enable, write_disable_cmd, ev_soft_reset, ev_op_done} = 4'h0;
    {ev_suspend, ev_resume, ev_perm_lock_prog, data_line_two_n} = 4'h1;
    {miscompares, checks_done, rej_cnt, stb_cnt, cyc} = '0;
    id_addr = '0;
    seed = 32'h0000002f;
    do_reset(1'b0, 1'b0, 1'b1);
    check("status", device_status, 8'h00);
    check("config", device_configuration, cfg_exp(1'b0, 1'b1, 1'b0));
    $display("reset test done");
    {busy_in, m_busy} = 2'b11;
    pulse_wel();
    host.xfer(OPC_READ_STATUS, 16'h0000, 0, rd);
    check("serial status", rd, 8'h83);
    host.xfer(OPC_READ_CONFIG, 16'h0000, 0, rd);
    check("serial config", rd, cfg_exp(1'b0, 1'b1, 1'b0));
    $display("serial read test done");
    for (int q = 0; q < 2; q++) begin
      quad_mode = q[0];
      host.pause_seq(obs);
      check("pause", {3'h0, obs}, (q == 1) ? 8'h04 : 8'h0e);
    end
    quad_mode = 1'b0;
    host.xfer(OPC_READ_STATUS, 16'h0000, 0, rd);
    check("status after pause", rd, 8'h83);
    $display("pause test done");
    quad_burst();
    check("quad rejects", 8'(rej_cnt), 8'h04);
    quad_mode = 1'b1;
    quad_burst();
    check("quad mode rejects", 8'(rej_cnt), 8'h04);
    quad_mode = 1'b0;
    host.xfer(OPC_WRITE_STATUS, 16'h00ff, 16, rd);
    check("config write", device_configuration, 8'h8a);
    m_wel = 1'b0;
    check("latch after write", device_status, st_exp());
    quad_burst();
    check("quad accepted", 8'(rej_cnt), 8'h04);
    $display("quad test done");
    pulse_wel();
    host.xfer(OPC_WRITE_STATUS, 16'h0080, 16, rd);
    data_line_two_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    check("hw protect", {7'h00, hw_protected}, 8'h01);
    pulse_wel();
    host.xfer(OPC_WRITE_STATUS, 16'h0000, 16, rd);
    check("protected config", device_configuration, 8'h88);
    check("write strobes", 8'(stb_cnt), 8'h02);
    quad_mode = 1'b1;
    #1;
    check("hw protect quad", {7'h00, hw_protected}, 8'h00);
    {quad_mode, data_line_two_n} = 2'b01;
    $display("protect test done");
    do_reset(1'b1, 1'b1, 1'b0);
    check("nv status", device_status, 8'h20);
    check("nv config", device_configuration, 8'h80);
    do_reset(1'b0, 1'b0, 1'b1);
    $display("nonvolatile test done");
    rand_events(400);
    do_reset(1'b0, 1'b0, 1'b1);
    check("status after power cycle", device_status, 8'h00);
    $display("random test done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
